/* File: shared/chan4_pkg.sv */
// Shared constants and carrier types for the channel 4 output and control port.
// Assumes one sampling clock for the output side and a host serial clock for the control side.

package chan4_pkg;

    // ------------------------------------------------------------------
    // Output data layout
    // ------------------------------------------------------------------
    localparam int DATA_W = 10; // Converted sample width
    localparam int chan4_data_lsb = 0; // Bit that carries the least significant bit
    localparam int chan4_data_msb = 9; // Bit that carries the most significant bit
    localparam int FIFO_DEPTH = 8; // Sample buffer depth

    // ------------------------------------------------------------------
    // Output timing, in sampling clock cycles
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50; // Sampling clock period in ns
    localparam int DATA_DIV = 2; // Data updates every DATA_DIV sampling cycles
    localparam int OUTCLK_DIV = 4; // Forwarded clock period in sampling cycles
    localparam int PHASE_W = $clog2(OUTCLK_DIV); // Width of the phase counter
    localparam logic [1:0] PHASE_START = 2'h0; // Phase after alignment
    localparam logic [1:0] OUTCLK_RISE_PHASE = 2'h1; // Phase at which the forwarded clock rises
    localparam logic [1:0] OUTCLK_FALL_PHASE = 2'h3; // Phase at which the forwarded clock falls

    // ------------------------------------------------------------------
    // Serial control framing
    // ------------------------------------------------------------------
    localparam logic [4:0] FRAME_BITS = 5'h10; // Bits in a full frame
    localparam logic [4:0] HEADER_LAST = 5'h07; // Count at the last header bit
    localparam logic [4:0] FRAME_LAST = 5'h0F; // Count at the last frame bit
    localparam logic [6:0] CFG_ADDR = 7'h00; // Address of the configuration register
    localparam int CFG_OUT_EN_BIT = 0; // Output enable field position
    localparam int CFG_GRAY_BIT = 1; // Gray coding field position

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [5:0] spare; // Reads back as written
        logic gray; // Gray coded output when set
        logic out_en; // Output port running when set
    } cfg_t;

    localparam cfg_t CFG_RESET = 8'h01; // Default: output on, binary coding

    typedef struct packed {
        logic range; // Input above or below the convertible range
        logic [DATA_W-1:0] data; // Converted value
    } sample_t;

endpackage

/* File: src/sample_fifo.sv */
// Synchronous FIFO between the converter core and the output serializer.
// Assumes both sides run on one clock; DEPTH is a power of two.
`timescale 1ns/1ps

module sample_fifo
#(
    parameter int WIDTH = 11,
    parameter int DEPTH = 8
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);

    // ------------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------------
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH]; // Sample storage
    logic [AW-1:0] wr_ptr; // Next slot to write
    logic [AW-1:0] rd_ptr; // Oldest slot
    logic [AW:0] count; // Words held
    logic [AW-1:0] next_wr_ptr;
    logic [AW-1:0] next_rd_ptr;
    logic [AW:0] next_count;
    logic next_in_ready;
    logic push; // Word accepted
    logic pop; // Word drained

    assign out_data = mem[rd_ptr];
    assign out_valid = (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer and fill level updates
    always_comb
    begin
        next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
        next_count = (AW+1)'(count + (AW+1)'(push) - (AW+1)'(pop));
        // Ready is registered so the source sees a clean flop
        next_in_ready = (next_count < (AW+1)'(DEPTH));
    end

    // Control registers
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            in_ready <= next_in_ready;
        end
    end

    // Storage write, no reset needed on data
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

endmodule // sample_fifo

/* File: src/chan4_port.sv */
// Channel 4 double data rate output port with its serial control port and alignment input.
// Assumes the core delivers samples on clk; the host clocks the control port on sclk.
`timescale 1ns/1ps

// Overview of operation
// - Ten data bits, bit zero least significant
// - Data updates at half the sampling rate
// - Range flag high while sample out of range
// - Forwarded clock runs at quarter sampling rate
// - Serial clock moves data only while selected
// - Serial data shifts on rising serial clock
// - Host data shifted in only while selected
// - Device data shifted out only while selected
// - Control reset restores defaults without clock
// - Alignment input is active high
module chan4_port
(
    input wire logic clk,
    input wire logic reset,
    input wire chan4_pkg::sample_t sample_in,
    input wire logic sample_valid,
    output logic sample_ready,
    input wire logic align_in_p,
    input wire logic align_in_n,
    input wire logic sclk,
    input wire logic csn,
    input wire logic mosi,
    input wire logic rstn,
    output logic miso,
    output logic miso_oe,
    output logic [chan4_pkg::DATA_W-1:0] chan4_data,
    output logic chan4_range_flag,
    output logic chan4_out_clk
);

    // ------------------------------------------------------------------
    // Sample buffer
    // ------------------------------------------------------------------
    chan4_pkg::sample_t head; // Oldest buffered sample
    logic head_valid; // Buffer not empty
    logic load; // Data slot boundary
    logic drain; // Take a sample this cycle
    logic fifo_ready; // Buffer has room

    sample_fifo
    #(
        .WIDTH($bits(chan4_pkg::sample_t)),
        .DEPTH(chan4_pkg::FIFO_DEPTH)
    )
    u_fifo
    (
        .clk(clk),
        .reset(reset),
        .in_data(sample_in),
        .in_valid(sample_valid),
        .in_ready(fifo_ready),
        .out_data(head),
        .out_valid(head_valid),
        .out_ready(drain)
    );

    // Ready comes straight from the buffer's registered ready
    assign sample_ready = fifo_ready;

    // ------------------------------------------------------------------
    // Reset combinations
    // ------------------------------------------------------------------
    logic cfg_clr; // Clears configuration in both domains
    logic frame_clr; // Also ends a frame when select rises

    assign cfg_clr = reset || !rstn;
    assign frame_clr = cfg_clr || csn;

    // ------------------------------------------------------------------
    // Serial shift logic, serial clock domain
    // ------------------------------------------------------------------
    logic [4:0] bit_count; // Bits taken in this frame
    logic [14:0] shift_in; // Received bits, newest at bit 0
    logic [7:0] shift_out; // Read data still to send
    logic [4:0] next_bit_count;
    logic [14:0] next_shift_in;
    logic [7:0] next_shift_out;
    logic next_miso;
    logic [7:0] header; // Command byte as it completes
    logic [15:0] word; // Full frame as it completes
    chan4_pkg::cfg_t cfg_spi; // Configuration as written by the host
    chan4_pkg::cfg_t next_cfg_spi;
    logic cfg_toggle; // Flips once per configuration write
    logic next_cfg_toggle;
    logic cfg_write; // Last bit of a write to the configuration address

    assign header = {shift_in[6:0], mosi};
    assign word = {shift_in, mosi};

    // Shift and count on each rising serial clock edge inside a frame
    always_comb
    begin
        next_bit_count = (bit_count == chan4_pkg::FRAME_BITS) ? bit_count : 5'(bit_count + 5'h01);
        next_shift_in = {shift_in[13:0], mosi};
        next_shift_out = {shift_out[6:0], 1'b0};
        next_miso = shift_out[7];
        if (bit_count == chan4_pkg::HEADER_LAST)
        begin
            // Read command: first data bit leaves on this same edge
            if (!header[7] && header[6:0] == chan4_pkg::CFG_ADDR)
            begin
                next_miso = cfg_spi[7];
                next_shift_out = {cfg_spi[6:0], 1'b0};
            end
            else
            begin
                next_miso = 1'b0;
                next_shift_out = 8'h00;
            end
        end
    end

    // Frame registers, cleared whenever select is high
    always_ff @(posedge sclk or posedge frame_clr)
    begin
        if (frame_clr)
        begin
            bit_count <= 5'h00;
            shift_in <= 15'h0000;
            shift_out <= 8'h00;
            miso <= 1'b0;
            miso_oe <= 1'b0;
        end
        else
        begin
            bit_count <= next_bit_count;
            shift_in <= next_shift_in;
            shift_out <= next_shift_out;
            miso <= next_miso;
            miso_oe <= 1'b1;
        end
    end

    assign cfg_write = !csn && bit_count == chan4_pkg::FRAME_LAST && word[15] && word[14:8] == chan4_pkg::CFG_ADDR;

    // Configuration write and its crossing toggle
    always_comb
    begin
        next_cfg_spi = cfg_spi;
        next_cfg_toggle = cfg_toggle;
        if (cfg_write)
        begin
            next_cfg_spi = word[7:0];
            next_cfg_toggle = !cfg_toggle;
        end
    end

    // Configuration register, held at default by the control reset
    always_ff @(posedge sclk or posedge cfg_clr)
    begin
        if (cfg_clr)
        begin
            cfg_spi <= chan4_pkg::CFG_RESET;
            cfg_toggle <= 1'b0;
        end
        else
        begin
            cfg_spi <= next_cfg_spi;
            cfg_toggle <= next_cfg_toggle;
        end
    end

    // ------------------------------------------------------------------
    // Crossings into the sampling clock domain
    // ------------------------------------------------------------------
    logic tog_s1; // First stage, read only by tog_s2
    logic tog_s2;
    logic tog_s3;
    logic align_s1; // First stage, read only by align_s2
    logic align_s2;
    logic align_s3;
    logic align_level; // Differential input seen as one level
    logic align_edge; // One cycle on a rising alignment request
    chan4_pkg::cfg_t cfg; // Configuration used by the output logic
    chan4_pkg::cfg_t next_cfg;

    assign align_level = align_in_p && !align_in_n;
    assign align_edge = align_s2 && !align_s3;

    // Take the host word once its toggle has settled; the word is stable by then
    always_comb
    begin
        next_cfg = (tog_s2 != tog_s3) ? cfg_spi : cfg;
    end

    // Synchronisers and the local configuration copy
    always_ff @(posedge clk or posedge cfg_clr)
    begin
        if (cfg_clr)
        begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
            cfg <= chan4_pkg::CFG_RESET;
        end
        else
        begin
            tog_s1 <= cfg_toggle;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
            cfg <= next_cfg;
        end
    end

    // Alignment synchroniser
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            align_s1 <= 1'b0;
            align_s2 <= 1'b0;
            align_s3 <= 1'b0;
        end
        else
        begin
            align_s1 <= align_level;
            align_s2 <= align_s1;
            align_s3 <= align_s2;
        end
    end

    // ------------------------------------------------------------------
    // Output serializer
    // ------------------------------------------------------------------
    logic [chan4_pkg::PHASE_W-1:0] phase; // Position within one forwarded clock period
    logic [chan4_pkg::PHASE_W-1:0] next_phase;
    logic [chan4_pkg::DATA_W-1:0] next_data;
    logic next_range;
    logic next_out_clk;
    logic [chan4_pkg::DATA_W-1:0] coded; // Head sample after optional gray coding

    // Slots start on even phases, so data changes mid-way between clock edges
    assign load = (phase[0] == 1'b0);
    // No drain on a realignment edge, so data never moves together with the parked clock
    assign drain = load && cfg.out_en && head_valid && !align_edge;
    assign coded = cfg.gray ? (head.data ^ (head.data >> 1)) : head.data;

    // Next data, flag, clock and phase
    always_comb
    begin
        next_phase = align_edge ? chan4_pkg::PHASE_START : chan4_pkg::PHASE_W'(phase + 1'b1);
        next_data = chan4_data;
        next_range = chan4_range_flag;
        next_out_clk = chan4_out_clk;
        if (drain)
        begin
            // Bit order carried straight through, lsb to bit zero
            next_data[chan4_pkg::chan4_data_msb:chan4_pkg::chan4_data_lsb] = coded;
            next_range = head.range;
        end
        if (!cfg.out_en || align_edge)
        begin
            // Stopped or realigning: clock parked low
            next_out_clk = 1'b0;
        end
        else if (phase == chan4_pkg::OUTCLK_RISE_PHASE)
        begin
            next_out_clk = 1'b1;
        end
        else if (phase == chan4_pkg::OUTCLK_FALL_PHASE)
        begin
            next_out_clk = 1'b0;
        end
    end

    // Output registers
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            phase <= chan4_pkg::PHASE_START;
            chan4_data <= '0;
            chan4_range_flag <= 1'b0;
            chan4_out_clk <= 1'b0;
        end
        else
        begin
            phase <= next_phase;
            chan4_data <= next_data;
            chan4_range_flag <= next_range;
            chan4_out_clk <= next_out_clk;
        end
    end

    // ------------------------------------------------------------------
    // Checks, sampling clock domain
    // ------------------------------------------------------------------
    property p_data_lsb_msb;
        @(posedge clk) disable iff (reset)
        drain && !cfg.gray |=> chan4_data == $past(head.data);
    endproperty
    a_data_lsb_msb: assert property (p_data_lsb_msb) else $error("data bits not carried in order");

    property p_data_rate;
        @(posedge clk) disable iff (reset)
        !load |=> $stable(chan4_data);
    endproperty
    a_data_rate: assert property (p_data_rate) else $error("data changed off a slot boundary");

    property p_range_flag;
        @(posedge clk) disable iff (reset)
        drain |=> chan4_range_flag == $past(head.range);
    endproperty
    a_range_flag: assert property (p_range_flag) else $error("range flag does not follow its sample");

    sequence s_clk_high_two;
        chan4_out_clk ##1 chan4_out_clk ##1 !chan4_out_clk;
    endsequence

    property p_out_clk_quarter;
        @(posedge clk) disable iff (reset || align_edge || !cfg.out_en)
        $rose(chan4_out_clk) |-> s_clk_high_two ##1 !chan4_out_clk ##1 chan4_out_clk;
    endproperty
    a_out_clk_quarter: assert property (p_out_clk_quarter) else $error("forwarded clock not a quarter rate");

    property p_data_centred;
        @(posedge clk) disable iff (reset)
        $changed(chan4_data) |-> $stable(chan4_out_clk);
    endproperty
    a_data_centred: assert property (p_data_centred) else $error("data and clock moved together");

    property p_cfg_default;
        @(posedge clk) disable iff (reset)
        !rstn |-> cfg == chan4_pkg::CFG_RESET;
    endproperty
    a_cfg_default: assert property (p_cfg_default) else $error("configuration not default in reset");

    property p_align;
        @(posedge clk) disable iff (reset)
        align_edge |=> phase == chan4_pkg::PHASE_START && !chan4_out_clk;
    endproperty
    a_align: assert property (p_align) else $error("alignment did not restart the output");

    // ------------------------------------------------------------------
    // Checks, serial side
    // ------------------------------------------------------------------
    // Sampled on clk, because sclk stands still while deselected
    property p_idle_count;
        @(posedge clk) disable iff (cfg_clr)
        csn |-> bit_count == 5'h00;
    endproperty
    a_idle_count: assert property (p_idle_count) else $error("bits counted while deselected");

    sequence s_write_end;
        cfg_write;
    endsequence

    property p_cfg_write;
        @(posedge sclk) disable iff (cfg_clr)
        s_write_end |=> cfg_spi == $past(word[7:0]) && cfg_toggle != $past(cfg_toggle);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("configuration write not stored");

    property p_miso_select;
        @(posedge clk) disable iff (cfg_clr)
        miso_oe |-> !csn;
    endproperty
    a_miso_select: assert property (p_miso_select) else $error("data driven out while deselected");

endmodule // chan4_port

/* File: verification/chan4_partner.sv */
// Far-side model: receiving logic on the output port and the serial control host.
// Assumes the bench calls xfer between its own steps; sclk stands still outside frames.
`timescale 1ns/1ps

module chan4_partner
(
    input wire logic reset,
    input wire logic [chan4_pkg::DATA_W-1:0] chan4_data,
    input wire logic chan4_range_flag,
    input wire logic chan4_out_clk,
    input wire logic miso,
    input wire logic miso_oe,
    output logic sclk,
    output logic csn,
    output logic mosi
);
    // ------------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------------
    chan4_pkg::sample_t rxq[$]; // Captured samples in arrival order

    // One capture on each edge of the forwarded clock
    always @(chan4_out_clk)
    begin
        if (!reset)
        begin
            rxq.push_back({chan4_range_flag, chan4_data});
        end
    end

    // ------------------------------------------------------------------
    // Serial host
    // ------------------------------------------------------------------
    // Idle: deselected, clock parked low
    initial
    begin
        sclk = 1'b0;
        csn = 1'b1;
        mosi = 1'b0;
    end

    // One 16-bit frame, MSB first; returns the device's data byte
    task xfer(input logic [15:0] word, output logic [7:0] rd);
        int i;
        begin
            rd = 8'h00;
            csn = 1'b0;
            for (i = 15; i >= 0; i--)
            begin
                mosi = word[i];
                #62.5;
                sclk = 1'b1;
                #62.5;
                // Device bit set by the rise just made in this step is settled here
                if (i >= 1 && i <= 8)
                begin
                    // An undriven line shows the inverse, never a stale bit
                    rd[i-1] = miso_oe ? miso : ~miso;
                end
                sclk = 1'b0;
            end
            #62.5;
            csn = 1'b1;
            // Released line shows no stale value
            mosi = ~mosi;
            #300;
        end
    endtask
endmodule // chan4_partner

/* File: verification/chan4_port_tb_top.sv */
// Self-checking bench for the channel 4 output and control port.
// Assumes the partner model holds the receiver and the serial host.
`timescale 1ns/1ps

module chan4_port_tb_top;
    logic clk = 1'b0; // Sampling clock, 50 ns
    logic reset = 1'b1; // Block reset
    chan4_pkg::sample_t sample_in = '0; // Core sample
    logic sample_valid = 1'b0; // Sample offered
    logic sample_ready;
    logic align_in_p = 1'b0; // Alignment pair, idle
    logic align_in_n = 1'b1;
    logic rstn = 1'b1; // Control reset, inactive
    logic sclk;
    logic csn;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic [chan4_pkg::DATA_W-1:0] chan4_data;
    logic chan4_range_flag;
    logic chan4_out_clk;
    int miscompares = 0; // Mismatch count
    int n_tests = 0; // Comparison count
    int cyc = 0; // Cycle count for the hang limit

    // ------------------------------------------------------------------
    // Clock, instances, hang limit
    // ------------------------------------------------------------------
    always #25 clk = ~clk;

    chan4_port chan4_port_inst (.clk(clk), .reset(reset), .sample_in(sample_in),
        .sample_valid(sample_valid), .sample_ready(sample_ready), .align_in_p(align_in_p),
        .align_in_n(align_in_n), .sclk(sclk), .csn(csn), .mosi(mosi), .rstn(rstn), .miso(miso),
        .miso_oe(miso_oe), .chan4_data(chan4_data), .chan4_range_flag(chan4_range_flag),
        .chan4_out_clk(chan4_out_clk));

    chan4_partner chan4_partner_inst (.reset(reset), .chan4_data(chan4_data),
        .chan4_range_flag(chan4_range_flag), .chan4_out_clk(chan4_out_clk), .miso(miso),
        .miso_oe(miso_oe), .sclk(sclk), .csn(csn), .mosi(mosi));

    // Ceiling well above the expected run of about 550 cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            miscompares++;
            conclude();
        end
    end

    // ------------------------------------------------------------------
    // Compare and report
    // ------------------------------------------------------------------
    task cmp_sample(input chan4_pkg::sample_t got, input chan4_pkg::sample_t exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task conclude;
        if (miscompares == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Forwarded clock changes seen over n cycles
    task count_toggles(input int n, output int t);
        logic last;
        begin
            t = 0;
            last = chan4_out_clk;
            repeat (n)
            begin
                @(negedge clk);
                if (chan4_out_clk !== last)
                    t++;
                last = chan4_out_clk;
            end
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Fill the buffer until refused, then check order, coding and flags at the receiver
    task stream_check(input int base, input logic gray);
        chan4_pkg::sample_t ex[24];
        logic [9:0] d;
        logic full;
        int k;
        int j;
        begin
            full = 1'b0;
            chan4_partner_inst.rxq.delete();
            for (k = 0; k < 24; k++)
            begin
                d = 10'(base + k * 37);
                ex[k] = {k[1], gray ? (d ^ (d >> 1)) : d};
                @(negedge clk);
                sample_in = {k[1], d};
                sample_valid = 1'b1;
                while (sample_ready !== 1'b1)
                begin
                    full = 1'b1;
                    @(negedge clk);
                end
            end
            @(negedge clk);
            sample_valid = 1'b0;
            repeat (60) @(negedge clk);
            cmp_byte({7'h00, full}, 8'h01); // Offers held off once the buffer filled
            j = 0;
            while (j < chan4_partner_inst.rxq.size() && chan4_partner_inst.rxq[j] !== ex[0])
                j++;
            for (k = 0; k < 24; k++)
                cmp_sample(chan4_partner_inst.rxq[j+k], ex[k]);
        end
    endtask

    // Store, read back, and read an unmapped address
    task spi_check;
        logic [7:0] rd;
        begin
            chan4_partner_inst.xfer(16'h8003, rd);
            chan4_partner_inst.xfer(16'h0000, rd);
            cmp_byte(rd, 8'h03); // Setting read back
            chan4_partner_inst.xfer(16'h0500, rd);
            cmp_byte(rd, 8'h00); // Unmapped address reads zero
            cmp_byte({7'h00, miso_oe}, 8'h00); // Not driven once deselected
        end
    endtask

    // Output off, then control reset brings defaults back and ignores frames
    task rstn_check;
        logic [7:0] rd;
        int t;
        begin
            chan4_partner_inst.xfer(16'h8002, rd);
            repeat (8) @(negedge clk);
            count_toggles(16, t);
            cmp_byte(8'(t), 8'h00); // Output stopped before control reset
            rstn = 1'b0;
            chan4_partner_inst.xfer(16'h80FC, rd);
            count_toggles(16, t);
            cmp_byte(8'(t), 8'h08); // Default setting restarts output
            rstn = 1'b1;
            chan4_partner_inst.xfer(16'h0000, rd);
            cmp_byte(rd, 8'h01); // Frame during control reset had no effect
        end
    endtask

    // Alignment request restarts the forwarded clock phase
    // Raised just after a clock rise, so the restart differs from the free-running phase
    task align_check;
        @(posedge chan4_out_clk);
        @(negedge clk);
        align_in_p = 1'b1;
        align_in_n = 1'b0;
        repeat (4) @(negedge clk);
        cmp_byte({7'h00, chan4_out_clk}, 8'h00); // Forced low after request
        repeat (2) @(negedge clk);
        cmp_byte({7'h00, chan4_out_clk}, 8'h01); // First high half after restart
        align_in_p = 1'b0;
        align_in_n = 1'b1;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        int t;
        @(negedge clk);
        cmp_sample({chan4_range_flag, chan4_data}, 11'h000); // Outputs clear in reset
        cmp_byte({5'h00, sample_ready, miso_oe, chan4_out_clk}, 8'h00); // Idle in reset
        @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        count_toggles(16, t);
        cmp_byte(8'(t), 8'h08); // Quarter-rate forwarded clock
        stream_check(256, 1'b0);
        spi_check();
        stream_check(512, 1'b1);
        rstn_check();
        align_check();
        conclude();
    end
endmodule // chan4_port_tb_top
